//--- logic/tfdd_digit_decoder.sv
module tfdd_digit_decoder #(
  parameter bit MSD_ONLY = 1'b0
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        nrst_in,
  input  wire logic [tfdd_pkg::BCD_W-1:0]  bcd_in,
  input  wire logic                        digit_blank_n_in,
  output logic      [tfdd_pkg::BCD_W-1:0]  bcd_out,
  output logic      [tfdd_pkg::SEG_W-1:0]  seg_out
);

  logic [tfdd_pkg::BCD_W-1:0] bcd_reg;
  logic [tfdd_pkg::SEG_W-1:0] seg_reg;
  logic [tfdd_pkg::SEG_W-1:0] seg_next;
  logic [tfdd_pkg::BCD_W-1:0] code;
  logic                       msd_void;

  assign code     = MSD_ONLY ? {2'b00, bcd_reg[1:0]} : bcd_reg;
  assign msd_void = MSD_ONLY && (bcd_reg[1:0] == 2'b11);
  assign bcd_out  = bcd_reg;
  assign seg_out  = seg_reg;

  always_comb
  begin
    case (code)
      4'h0:    seg_next = tfdd_pkg::SEG_ZERO;
      4'h1:    seg_next = tfdd_pkg::SEG_ONE;
      4'h2:    seg_next = tfdd_pkg::SEG_TWO;
      4'h3:    seg_next = tfdd_pkg::SEG_THREE;
      4'h4:    seg_next = tfdd_pkg::SEG_FOUR;
      4'h5:    seg_next = tfdd_pkg::SEG_FIVE;
      4'h6:    seg_next = tfdd_pkg::SEG_SIX;
      4'h7:    seg_next = tfdd_pkg::SEG_SEVEN;
      4'h8:    seg_next = tfdd_pkg::SEG_EIGHT;
      4'h9:    seg_next = tfdd_pkg::SEG_NINE;
      default: seg_next = tfdd_pkg::SEG_BLANK;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      bcd_reg <= '0;
      seg_reg <= tfdd_pkg::SEG_BLANK;
    end
    else
    begin
      bcd_reg <= bcd_in;
      seg_reg <= (digit_blank_n_in && !msd_void) ? seg_next
                                                  : tfdd_pkg::SEG_BLANK;
    end
  end

  chk_blank_dark: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !digit_blank_n_in |=> seg_out == tfdd_pkg::SEG_BLANK)
    else $error("blanked digit shows segments");

  chk_msd_limit: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    MSD_ONLY && bcd_reg[1:0] == 2'b11 |=> seg_out == tfdd_pkg::SEG_BLANK)
    else $error("first digit shows code three");

  chk_decode_two: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    digit_blank_n_in && bcd_reg == 4'h2 |=> seg_out == tfdd_pkg::SEG_TWO)
    else $error("code two wrong pattern");

  chk_decode_eight: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !MSD_ONLY && digit_blank_n_in && bcd_reg == 4'h8
      |=> seg_out == tfdd_pkg::SEG_EIGHT)
    else $error("code eight wrong pattern");

  chk_latch_path: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    bcd_in == 4'h1 ##1 digit_blank_n_in |=> seg_out == tfdd_pkg::SEG_ONE)
    else $error("latched code one not shown");

endmodule

//--- logic/tfdd_display_top.sv
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
module tfdd_display_top (
  input  wire logic                       ref_clk_in,
  input  wire logic                       nrst_in,
  // Register bus
  input  wire logic [tfdd_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic [2:0]                  s_axi_awprot_in,
  input  wire logic                        s_axi_awvalid_in,
  output logic                             s_axi_awready_out,
  input  wire logic [tfdd_pkg::DATA_W-1:0] s_axi_wdata_in,
  input  wire logic [3:0]                  s_axi_wstrb_in,
  input  wire logic                        s_axi_wvalid_in,
  output logic                             s_axi_wready_out,
  output logic      [1:0]                  s_axi_bresp_out,
  output logic                             s_axi_bvalid_out,
  input  wire logic                        s_axi_bready_in,
  input  wire logic [tfdd_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic [2:0]                  s_axi_arprot_in,
  input  wire logic                        s_axi_arvalid_in,
  output logic                             s_axi_arready_out,
  output logic      [tfdd_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic      [1:0]                  s_axi_rresp_out,
  output logic                             s_axi_rvalid_out,
  input  wire logic                        s_axi_rready_in,
  // Controller side, digit one in the low nibble
  input  wire logic [27:0]                 digit_bcd_in,
  input  wire logic                        digit_blank_n_in,
  input  wire logic                        neg_sign_in,
  // Display side, digit one in the low seven bits
  output logic      [48:0]                 seg_out,
  output logic      [6:0]                  dp_out
);

  localparam int ND = tfdd_pkg::DIGITS;
  localparam int SW = tfdd_pkg::SEG_W;
  localparam int BW = tfdd_pkg::BCD_W;
  localparam int PW = ND * BW + 2;

  // Pin side, synchronised
  logic [PW-1:0]    pins_sync;
  logic [ND*BW-1:0] bcd_sync;
  logic             blank_n_sync;
  logic             sign_sync;

  logic [ND*BW-1:0] bcd_latched;
  logic [ND*SW-1:0] dec_seg;
  logic [ND-1:0]    dec_blank_n;
  logic [ND-1:0]    out_blank;

  logic [ND*SW-1:0] seg_reg;
  logic [ND-1:0]    dp_reg;
  logic             mode_reg;

  // Bus state
  tfdd_pkg::tfdd_wr_e          wr_state;
  tfdd_pkg::tfdd_rd_e          rd_state;
  logic                        aw_hold_reg;
  logic                        w_hold_reg;
  logic [tfdd_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [tfdd_pkg::DATA_W-1:0] wdata_reg;
  logic [3:0]                  wstrb_reg;
  logic [1:0]                  bresp_reg;
  logic [tfdd_pkg::DATA_W-1:0] rdata_reg;
  logic [1:0]                  rresp_reg;

  tfdd_pin_sync #(
    .W (PW)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .pin_in     ({neg_sign_in, digit_blank_n_in, digit_bcd_in}),
    .level_out  (pins_sync)
  );

  assign bcd_sync     = pins_sync[ND*BW-1:0];
  assign blank_n_sync = pins_sync[ND*BW];
  assign sign_sync    = pins_sync[ND*BW+1];

  assign dec_blank_n = ~(tfdd_pkg::LINE_BLANK_MASK & {ND{~blank_n_sync}});

  genvar gi;
  generate
    for (gi = 0; gi < ND; gi++)
    begin : g_dig
      tfdd_digit_decoder #(
        .MSD_ONLY (gi == 0)
      ) u_dec (
        .ref_clk_in       (ref_clk_in),
        .nrst_in          (nrst_in),
        .bcd_in           (bcd_sync[gi*BW +: BW]),
        .digit_blank_n_in (dec_blank_n[gi]),
        .bcd_out          (bcd_latched[gi*BW +: BW]),
        .seg_out          (dec_seg[gi*SW +: SW])
      );
    end
  endgenerate

  assign out_blank = mode_reg ? tfdd_pkg::OFFSET_BLANK : '0;

  logic [ND*SW-1:0] seg_gated;
  logic [ND*SW-1:0] sign_mask;
  logic [ND-1:0]    dp_next;

  generate
    for (gi = 0; gi < ND; gi++)
    begin : g_gate
      assign seg_gated[gi*SW +: SW] =
        out_blank[gi] ? tfdd_pkg::SEG_BLANK : dec_seg[gi*SW +: SW];
    end
  endgenerate

  assign sign_mask = (ND*SW)'(sign_sync)
                     << (tfdd_pkg::SIGN_DIGIT * SW + tfdd_pkg::SEG_G_BIT);

  assign dp_next = mode_reg ? tfdd_pkg::DP_OFFSET_MASK
                            : tfdd_pkg::DP_TUNED_MASK;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      seg_reg <= '0;
      dp_reg  <= '0;
    end
    else
    begin
      seg_reg <= seg_gated | sign_mask;
      dp_reg  <= dp_next;
    end
  end

  assign seg_out = seg_reg;
  assign dp_out  = dp_reg;

  // Write channel: address and data in either order
  logic                        aw_take;
  logic                        w_take;
  logic                        wr_fire;
  logic [tfdd_pkg::ADDR_W-1:0] wr_addr;
  logic [tfdd_pkg::DATA_W-1:0] wr_data;
  logic [3:0]                  wr_strb;
  logic                        wr_ctrl;
  logic                        wr_known;

  assign s_axi_awready_out = (wr_state == tfdd_pkg::WR_WAIT) && !aw_hold_reg;
  assign s_axi_wready_out  = (wr_state == tfdd_pkg::WR_WAIT) && !w_hold_reg;
  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take  = s_axi_wvalid_in && s_axi_wready_out;
  assign wr_fire = (aw_hold_reg || aw_take) && (w_hold_reg || w_take);
  assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr_in;
  assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata_in;
  assign wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb_in;
  assign wr_ctrl = {wr_addr[tfdd_pkg::ADDR_W-1:2], 2'b00}
                   == tfdd_pkg::CTRL_OFS;
  // Read-only words accept writes silently
  assign wr_known = wr_ctrl
    || {wr_addr[tfdd_pkg::ADDR_W-1:2], 2'b00} == tfdd_pkg::STATUS_OFS
    || {wr_addr[tfdd_pkg::ADDR_W-1:2], 2'b00} == tfdd_pkg::BCD_OFS
    || {wr_addr[tfdd_pkg::ADDR_W-1:2], 2'b00} == tfdd_pkg::SEG_LO_OFS
    || {wr_addr[tfdd_pkg::ADDR_W-1:2], 2'b00} == tfdd_pkg::SEG_HI_OFS;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wr_state    <= tfdd_pkg::WR_WAIT;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bresp_reg   <= tfdd_pkg::RESP_OKAY;
      mode_reg    <= tfdd_pkg::CTRL_MODE_RST;
    end
    else
    begin
      case (wr_state)
        tfdd_pkg::WR_WAIT:
        begin
          if (aw_take)
          begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_in;
          end
          if (w_take)
          begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_in;
            wstrb_reg  <= s_axi_wstrb_in;
          end
          if (wr_fire)
          begin
            wr_state    <= tfdd_pkg::WR_RESP;
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bresp_reg   <= wr_known ? tfdd_pkg::RESP_OKAY
                                    : tfdd_pkg::RESP_SLVERR;
            if (wr_ctrl && wr_strb[0])
              mode_reg <= wr_data[tfdd_pkg::CTRL_MODE_BIT];
          end
        end
        tfdd_pkg::WR_RESP:
        begin
          if (s_axi_bready_in)
            wr_state <= tfdd_pkg::WR_WAIT;
        end
        default: wr_state <= tfdd_pkg::WR_WAIT;
      endcase
    end
  end

  assign s_axi_bvalid_out = (wr_state == tfdd_pkg::WR_RESP);
  assign s_axi_bresp_out  = bresp_reg;

  // Read channel
  logic                        ar_take;
  logic [tfdd_pkg::ADDR_W-1:0] rd_word;
  logic                        sel_ctrl;
  logic                        sel_stat;
  logic                        sel_bcd;
  logic                        sel_seg_lo;
  logic                        sel_seg_hi;
  logic [tfdd_pkg::DATA_W-1:0] ctrl_word;
  logic [tfdd_pkg::DATA_W-1:0] stat_word;
  logic [tfdd_pkg::DATA_W-1:0] rd_mux;
  logic                        rd_known;

  assign s_axi_arready_out = (rd_state == tfdd_pkg::RD_IDLE);
  assign ar_take    = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_word    = {s_axi_araddr_in[tfdd_pkg::ADDR_W-1:2], 2'b00};
  assign sel_ctrl   = rd_word == tfdd_pkg::CTRL_OFS;
  assign sel_stat   = rd_word == tfdd_pkg::STATUS_OFS;
  assign sel_bcd    = rd_word == tfdd_pkg::BCD_OFS;
  assign sel_seg_lo = rd_word == tfdd_pkg::SEG_LO_OFS;
  assign sel_seg_hi = rd_word == tfdd_pkg::SEG_HI_OFS;
  assign rd_known   = sel_ctrl | sel_stat | sel_bcd | sel_seg_lo | sel_seg_hi;

  assign ctrl_word = tfdd_pkg::DATA_W'(mode_reg)
                     << tfdd_pkg::CTRL_MODE_BIT;
  assign stat_word =
      (tfdd_pkg::DATA_W'(blank_n_sync) << tfdd_pkg::STAT_BLANK_BIT)
    | (tfdd_pkg::DATA_W'(sign_sync) << tfdd_pkg::STAT_SIGN_BIT)
    | (tfdd_pkg::DATA_W'(mode_reg) << tfdd_pkg::STAT_MODE_BIT);

  // Segment words show digits 1-4, then 5-7 with points
  assign rd_mux =
      sel_ctrl   ? ctrl_word
    : sel_stat   ? stat_word
    : sel_bcd    ? {4'h0, bcd_latched}
    : sel_seg_lo ? {4'h0, seg_reg[4*SW-1:0]}
    : sel_seg_hi ? {4'h0, dp_reg, seg_reg[ND*SW-1:4*SW]}
    : '0;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rd_state  <= tfdd_pkg::RD_IDLE;
      rdata_reg <= '0;
      rresp_reg <= tfdd_pkg::RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        tfdd_pkg::RD_IDLE:
        begin
          if (ar_take)
          begin
            rd_state  <= tfdd_pkg::RD_DATA;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_known ? tfdd_pkg::RESP_OKAY
                                  : tfdd_pkg::RESP_SLVERR;
          end
        end
        tfdd_pkg::RD_DATA:
        begin
          if (s_axi_rready_in)
            rd_state <= tfdd_pkg::RD_IDLE;
        end
        default: rd_state <= tfdd_pkg::RD_IDLE;
      endcase
    end
  end

  assign s_axi_rvalid_out = (rd_state == tfdd_pkg::RD_DATA);
  assign s_axi_rdata_out  = rdata_reg;
  assign s_axi_rresp_out  = rresp_reg;

  // Checks
  chk_offset_outer_dark: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    mode_reg && !sign_sync |=> seg_out[4*SW-1:0] == '0
      && seg_out[ND*SW-1:6*SW] == '0)
    else $error("offset mode outer digits lit");

  chk_dp_tuned: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    nrst_in && !mode_reg ##1 !mode_reg
      |-> dp_out == tfdd_pkg::DP_TUNED_MASK)
    else $error("frequency point not on digit two");

  chk_dp_offset: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    mode_reg |=> dp_out == 7'h10)
    else $error("offset point not on digit five");

  chk_sign_segment: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    sign_sync |=> seg_out[3*SW+6])
    else $error("sign line did not light g");

  chk_minus_only: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !blank_n_sync ##1 sign_sync && !blank_n_sync
      |=> seg_out[4*SW-1:3*SW] == 7'h40)
    else $error("minus sign shows extra segments");

  chk_bresp_hold: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");

  chk_read_answer: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");

endmodule

//--- logic/tfdd_pin_sync.sv
module tfdd_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;
  logic [W-1:0] agree;

  // Glitch filter: take a bit only once two stages agree
  assign agree     = ~(s2_reg ^ s3_reg);
  assign level_out = level_reg;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end
    else
    begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= (agree & s3_reg) | (~agree & level_reg);
    end
  end

endmodule

//--- logic/tfdd_pkg.sv
// How it works
// - Seven separate BCD to segment decoders
// - Codes 0 to 3 light standard segments
// - Codes 4,5,7,8 light standard segments; 6 and 9 have no tail
// - First digit decodes two bits: 0,1,2,blank
// - Frequency mode: digit one most significant
// - Frequency mode lights digit two point
// - Offset mode uses digits five and six
// - Offset mode: point five, 1-4,7 blank
// - Blank line low darkens digits 1-4,7
// - Negative offset shows minus on digit four
// - Sign line lights digit four segment g
package tfdd_pkg;

  localparam int DIGITS = 7;
  localparam int BCD_W  = 4;
  localparam int SEG_W  = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] BCD_OFS    = 8'h08;
  localparam logic [ADDR_W-1:0] SEG_LO_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] SEG_HI_OFS = 8'h10;

  localparam int CTRL_MODE_BIT  = 0;
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam int STAT_BLANK_BIT = 0;
  localparam int STAT_SIGN_BIT  = 1;
  localparam int STAT_MODE_BIT  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Segment patterns, bit 0 = a up to bit 6 = g
  localparam logic [SEG_W-1:0] SEG_BLANK = 7'h00;
  localparam logic [SEG_W-1:0] SEG_ZERO  = 7'h3f;
  localparam logic [SEG_W-1:0] SEG_ONE   = 7'h06;
  localparam logic [SEG_W-1:0] SEG_TWO   = 7'h5b;
  localparam logic [SEG_W-1:0] SEG_THREE = 7'h4f;
  localparam logic [SEG_W-1:0] SEG_FOUR  = 7'h66;
  localparam logic [SEG_W-1:0] SEG_FIVE  = 7'h6d;
  localparam logic [SEG_W-1:0] SEG_SIX   = 7'h7c;
  localparam logic [SEG_W-1:0] SEG_SEVEN = 7'h07;
  localparam logic [SEG_W-1:0] SEG_EIGHT = 7'h7f;
  localparam logic [SEG_W-1:0] SEG_NINE  = 7'h67;
  localparam int SEG_G_BIT = 6;

  // Digit positions, index 0 is digit one
  localparam int SIGN_DIGIT = 3;
  localparam logic [DIGITS-1:0] DP_TUNED_MASK   = 7'h02;
  localparam logic [DIGITS-1:0] DP_OFFSET_MASK  = 7'h10;
  localparam logic [DIGITS-1:0] OFFSET_BLANK    = 7'h4f;
  localparam logic [DIGITS-1:0] LINE_BLANK_MASK = 7'h4f;

  typedef enum logic {WR_WAIT, WR_RESP} tfdd_wr_e;
  typedef enum logic {RD_IDLE, RD_DATA} tfdd_rd_e;

endpackage

//--- tb/tfdd_ctrl_model.sv
module tfdd_ctrl_model (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [1:0]  cmd_mode_in,
  input  wire logic [27:0] cmd_freq_in,
  input  wire logic [7:0]  cmd_offset_in,
  input  wire logic        cmd_neg_in,
  output logic      [27:0] digit_bcd_out,
  output logic             digit_blank_n_out,
  output logic             neg_sign_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Mode 0 tuned, 1 offset, 2 lock; code f is dark
  logic [27:0] bcd_next;
  logic        blank_n_next;

  always_comb
  begin
    bcd_next = cmd_freq_in;
    blank_n_next = 1'b1;
    if (cmd_mode_in != 2'h0)
    begin
      blank_n_next = 1'b0;
      bcd_next = 28'hfffffff;
      if (cmd_mode_in == 2'h1)
        bcd_next[23:16] = {cmd_offset_in[3:0], cmd_offset_in[7:4]};
    end
  end

  // Pins move just after the edge, like the real controller
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      digit_bcd_out <= 28'h0000000;
      digit_blank_n_out <= 1'b1;
      neg_sign_out <= 1'b0;
    end
    else
    begin
      digit_bcd_out <= bcd_next;
      digit_blank_n_out <= blank_n_next;
      neg_sign_out <= cmd_neg_in && (cmd_mode_in == 2'h1);
    end
  end
endmodule

//--- tb/tfdd_display_top_test.sv
module tfdd_display_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        nrst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [27:0] bcd;
  logic        blank_n;
  logic        neg;
  logic [48:0] seg;
  logic [6:0]  dp;
  logic [1:0]  c_mode;
  logic [27:0] c_freq;
  logic [7:0]  c_ofs;
  logic        c_neg;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          n_fail = 0;
  int          samples_checked = 0;

  tfdd_display_top u_tfdd_display_top (
    .ref_clk_in(clk), .nrst_in(nrst),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .digit_bcd_in(bcd),
    .digit_blank_n_in(blank_n), .neg_sign_in(neg),
    .seg_out(seg), .dp_out(dp)
  );

  tfdd_ctrl_model u_tfdd_ctrl_model (
    .ref_clk_in(clk), .nrst_in(nrst), .cmd_mode_in(c_mode),
    .cmd_freq_in(c_freq), .cmd_offset_in(c_ofs), .cmd_neg_in(c_neg),
    .digit_bcd_out(bcd), .digit_blank_n_out(blank_n),
    .neg_sign_out(neg)
  );

  always #5 clk = ~clk;

  function automatic logic [6:0] seg_of(input logic [3:0] c);
    case (c)
      4'h0: seg_of = 7'h3f;
      4'h1: seg_of = 7'h06;
      4'h2: seg_of = 7'h5b;
      4'h3: seg_of = 7'h4f;
      4'h4: seg_of = 7'h66;
      4'h5: seg_of = 7'h6d;
      4'h6: seg_of = 7'h7c;
      4'h7: seg_of = 7'h07;
      4'h8: seg_of = 7'h7f;
      4'h9: seg_of = 7'h67;
      default: seg_of = 7'h00;
    endcase
  endfunction

  // Expected {dp, segments}; top digit sees two bits only
  function automatic logic [55:0] disp(input logic [27:0] b,
    input logic bn, input logic ng, input logic md);
    logic [3:0] c;
    logic [6:0] s;
    disp = 56'h0;
    for (int i = 0; i < 7; i++)
    begin
      c = b[4*i+:4];
      if (i == 0)
        c = (c[1:0] == 2'h3) ? 4'hf : {2'h0, c[1:0]};
      s = seg_of(c);
      if (i != 4 && i != 5 && (!bn || md))
        s = 7'h00;
      if (i == 3 && ng)
        s[6] = 1'b1;
      disp[7*i+:7] = s;
    end
    disp[55:49] = md ? 7'h10 : 7'h02;
  endfunction

  task automatic tally(input logic ok, input logic [55:0] g,
    input logic [55:0] e);
    samples_checked++;
    if (!ok)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, 56'(g), 56'(e));
  endtask

  task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
    tally(g === e, 56'(g), 56'(e));
  endtask

  task automatic check_disp(input logic [55:0] g, input logic [55:0] e);
    tally(g === e, g, e);
  endtask

  // Pins need 7 edges to reach the segments; 12 leaves margin
  task automatic show(input logic [55:0] e);
    repeat (12) @(posedge clk);
    @(negedge clk);
    check_disp({dp, seg}, e);
    @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic aw_t;
    logic w_t;
    logic aw_ok;
    logic w_ok;
    logic b_t;
    int   n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_t = 1'b0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < 100)
    begin
      @(negedge clk);
      aw_t = awready && !aw_ok;
      w_t = wready && !w_ok;
      @(posedge clk);
      aw_ok = aw_ok || aw_t;
      w_ok = w_ok || w_t;
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
      n++;
    end
    while (!b_t && n < 200)
    begin
      @(negedge clk);
      b_t = bvalid;
      rsp = bresp;
      @(posedge clk);
      n++;
    end
    // A missing answer counts as a mismatch
    if (!b_t)
      n_fail++;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic ar_t;
    logic r_t;
    int   n;
    ar_t = 1'b0;
    r_t = 1'b0;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ar_t && n < 100)
    begin
      @(negedge clk);
      ar_t = arready;
      @(posedge clk);
      arvalid <= !ar_t;
      n++;
    end
    while (!r_t && n < 200)
    begin
      @(negedge clk);
      r_t = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      n++;
    end
    if (!r_t)
      n_fail++;
    rready <= 1'b0;
  endtask

  task automatic complete_run;
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Run is about 350 cycles; the limit is far above it
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  initial
  begin
    logic [55:0] e;
    clk = 1'b0;
    nrst = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, c_mode, c_freq, c_ofs, c_neg} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    show(disp(28'h0, 1'b1, 1'b0, 1'b0));
    rd_reg(tfdd_pkg::CTRL_OFS);
    check_word(rd, 32'h0);
    rd_reg(8'h20);
    check_word(rd, 32'h0);
    check_resp(rsp, 2'h2);
    wr_reg(8'h24, 32'h1);
    check_resp(rsp, 2'h2);
    for (int k = 0; k < 16; k++)
    begin
      c_freq <= {7{4'(k)}};
      show(disp({7{4'(k)}}, 1'b1, 1'b0, 1'b0));
    end
    c_freq <= 28'h2536751;
    e = disp(28'h2536751, 1'b1, 1'b0, 1'b0);
    show(e);
    rd_reg(tfdd_pkg::BCD_OFS);
    check_word(rd, 32'h02536751);
    rd_reg(tfdd_pkg::SEG_LO_OFS);
    check_word(rd, {4'h0, e[27:0]});
    c_mode <= 2'h2;
    show(disp(28'hfffffff, 1'b0, 1'b0, 1'b0));
    rd_reg(tfdd_pkg::STATUS_OFS);
    check_word(rd, 32'h0);
    wr_reg(tfdd_pkg::STATUS_OFS, 32'h7);
    check_resp(rsp, 2'h0);
    wr_reg(tfdd_pkg::CTRL_OFS, 32'h1);
    check_resp(rsp, 2'h0);
    c_mode <= 2'h1;
    c_ofs <= 8'h74;
    c_neg <= 1'b1;
    e = disp(28'hf47ffff, 1'b0, 1'b1, 1'b1);
    show(e);
    rd_reg(tfdd_pkg::STATUS_OFS);
    check_word(rd, 32'h6);
    rd_reg(tfdd_pkg::SEG_HI_OFS);
    check_word(rd, {4'h0, e[55:28]});
    c_neg <= 1'b0;
    show(disp(28'hf47ffff, 1'b0, 1'b0, 1'b1));
    c_mode <= 2'h0;
    c_freq <= 28'h1234567;
    show(disp(28'h1234567, 1'b1, 1'b0, 1'b1));
    wr_reg(tfdd_pkg::CTRL_OFS, 32'h0);
    rd_reg(tfdd_pkg::CTRL_OFS);
    check_word(rd, 32'h0);
    show(disp(28'h1234567, 1'b1, 1'b0, 1'b0));
    complete_run;
  end
endmodule
